// >>> hw/ascc_pkg.sv
package ascc_pkg;

   // flag word, clock and password widths
   localparam int IN_W   = 14;
   localparam int OUT_W  = 16;
   localparam int PROT_W = 20;
   localparam int RTC_W  = 48;
   localparam int PWD_W  = 32;

   // protection flag bit positions
   localparam int PB_VOLTAGE_BALANCE_COMPARISON_SIDE     = 0;
   localparam int PB_VB_HEALTHY  = 1;
   localparam int PB_VB_FAULT    = 2;
   localparam int PB_GEN_DIFF    = 19;
   // output flag bit of the inoperative alarm contact
   localparam int OB_INOPERATIVE = 0;

   // reset values
   localparam logic [PWD_W-1:0] PWD_DEFAULT = 32'h41414141;
   localparam logic [RTC_W-1:0] RTC_RESET   = 48'h0;

   // command port: one request per cycle
   typedef struct packed {
      logic             port_sel;   // 0 front panel, 1 remote
      logic             pwd_enter;  // present password
      logic             pwd_relock; // re-apply protection
      logic             pwd_change; // store new password (unlocked only)
      logic [PWD_W-1:0] pwd_data;
      logic             alarm_clear;
      logic             gate_write;
      logic             gate_enable;
      logic             ev_clear;   // confirmed clear request
      logic             rtc_write;
      logic [RTC_W-1:0] rtc_data;
   } ascc_cmd_t;

   // event record sent to the event store
   typedef struct packed {
      logic reset_cause; // logged on reset
      logic gate_state;  // 1 enabled, 0 inhibited
   } ascc_evt_t;

   // event-log sequencer states
   typedef enum logic [2:0] {
      EV_BOOT = 3'b001,
      EV_IDLE = 3'b010,
      EV_LOG  = 3'b100
   } ascc_evst_t;

endpackage

// >>> hw/ascc_top.sv
// Functional notes
// - 14-bit input word mirrors energised inputs
// - 16-bit output word, one bit per contact
// - 20-bit protection word, also feeds scheme
// - protection bits ordered, bit19 generator differential
// - bits 1 and 2 complementary once loaded; both 0 from reset until the first enabled edge
// - alarm indication follows front alarm indicator
// - alarm clear resets indication unless a source is active, releases latches
// - gate enabled: scheme drives contacts
// - gate inhibited: manual test only, out-of-service
// - output word shows scheme state always
// - log gate state on reset and change
// - gate writes only while unlocked
// - confirmed unlocked clear erases event store
// - event clear leaves alarm untouched
// - real-time clock readable and settable
// - output bit 0 reads inverted
// - password match unlocks, mismatch locks
`timescale 1ns/1ps
module ascc_top
   import ascc_pkg::*;
(
   // clock, reset, enable
   input  wire logic                         CORE_CLK_I,
   input  wire logic                         RST_N_I,
   input  wire logic                         CLK_EN_I,
   // isolated logic inputs (pins)
   input  wire logic [ascc_pkg::IN_W-1:0]    LOGIC_IN_I,
   // protection function outputs
   input  wire logic [ascc_pkg::PROT_W-1:0]  PROT_FUNC_I,
   // scheme logic and manual test contact states
   input  wire logic [ascc_pkg::OUT_W-1:0]   SCHEME_OUT_I,
   input  wire logic [ascc_pkg::OUT_W-1:0]   TEST_OUT_I,
   input  wire logic [ascc_pkg::OUT_W-1:0]   LATCH_MASK_I,
   input  wire logic                         INOPERATIVE_I,
   // alarm sources
   input  wire logic                         ALARM_ACTIVE_I,
   // command port
   input  wire ascc_pkg::ascc_cmd_t          CMD_I,
   // flag words
   output logic [ascc_pkg::IN_W-1:0]         INPUT_FLAG_O,
   output logic [ascc_pkg::OUT_W-1:0]        OUTPUT_FLAG_O,
   output logic [ascc_pkg::PROT_W-1:0]       PROT_FLAG_O,
   // scheme feed
   output logic [ascc_pkg::IN_W-1:0]         SCHEME_IN_O,
   output logic [ascc_pkg::PROT_W-1:0]       SCHEME_PROT_O,
   // contacts and indicators
   output logic [ascc_pkg::OUT_W-1:0]        CONTACT_O,
   output logic                              OUT_OF_SERVICE_O,
   output logic                              ALARM_PRESENT_O,
   output logic                              GATE_ENABLED_O,
   output logic [1:0]                        UNLOCKED_O,
   // event store
   output logic                              EV_VALID_O,
   output ascc_pkg::ascc_evt_t               EV_DATA_O,
   output logic                              EV_ERASE_O,
   // real-time clock
   output logic [ascc_pkg::RTC_W-1:0]        RTC_O
);
   import ascc_pkg::*;

   // pin synchronisers: first stage read only by second
   logic [IN_W-1:0]   in_s1_r;
   logic [IN_W-1:0]   in_s2_r;
   logic              inop_s1_r;
   logic              inop_s2_r;
   logic              alarm_s1_r;
   logic              alarm_s2_r;

   // state registers
   logic [IN_W-1:0]   in_flag_r;
   logic [OUT_W-1:0]  out_flag_r;
   logic [PROT_W-1:0] prot_flag_r;
   logic [OUT_W-1:0]  contact_r;
   logic [OUT_W-1:0]  latch_r;       // held latched contacts
   logic              alarm_r;
   logic              gate_r;
   logic              oos_r;
   logic [1:0]        unlock_r;      // one lock per access system
   logic [PWD_W-1:0]  pwd_r;
   logic [RTC_W-1:0]  rtc_r;
   logic              ev_valid_r;
   ascc_evt_t         ev_data_r;
   logic              ev_erase_r;
   ascc_evst_t        ev_st_r;

   // next values
   logic [PROT_W-1:0] prot_nxt;
   logic [OUT_W-1:0]  drive_nxt;
   logic [OUT_W-1:0]  latch_nxt;
   logic [OUT_W-1:0]  contact_nxt;
   logic [OUT_W-1:0]  out_flag_nxt;
   logic              alarm_nxt;
   logic              gate_nxt;
   logic [1:0]        unlock_nxt;
   ascc_evst_t        ev_st_nxt;

   // decoded command terms
   wire               port_unlocked;
   wire               gate_ok;
   wire               gate_changes;
   wire               ev_clear_ok;
   wire               pwd_match;
   wire               pwd_change_ok;

   // unlock state of the requesting access system
   function automatic logic unlocked_for(input logic [1:0] st, input logic sel);
      unlocked_for = sel ? st[1] : st[0];
   endfunction

   assign port_unlocked = unlocked_for(unlock_r, CMD_I.port_sel);
   assign pwd_match     = (CMD_I.pwd_data == pwd_r);
   // protected cells refused while locked
   assign gate_ok       = CMD_I.gate_write & port_unlocked;
   assign gate_changes  = gate_ok & (CMD_I.gate_enable != gate_r);
   assign ev_clear_ok   = CMD_I.ev_clear & port_unlocked;
   assign pwd_change_ok = CMD_I.pwd_change & port_unlocked;

   // voltage balance pair forced complementary from the fault bit
   always_comb
   begin
      prot_nxt                = PROT_FUNC_I;
      prot_nxt[PB_VB_HEALTHY] = ~PROT_FUNC_I[PB_VB_FAULT];
   end

   // latched contacts hold until an alarm clear releases them
   assign latch_nxt = CMD_I.alarm_clear ? '0
                    : (latch_r | (SCHEME_OUT_I & LATCH_MASK_I));
   assign drive_nxt = SCHEME_OUT_I | latch_r;

   // gate picks scheme or manual test as the contact source
   always_comb
   begin
      if (gate_r)
      begin
         contact_nxt = drive_nxt;
      end
      else
      begin
         contact_nxt = TEST_OUT_I;
      end
      contact_nxt[OB_INOPERATIVE] = ~inop_s2_r; // energised while healthy
   end

   // flag word shows scheme result, not physical contacts
   always_comb
   begin
      out_flag_nxt                 = drive_nxt;
      out_flag_nxt[OB_INOPERATIVE] = inop_s2_r;
   end

   // alarm indication holds until cleared; an active source beats the clear
   assign alarm_nxt = alarm_s2_r ? 1'b1
                    : (CMD_I.alarm_clear ? 1'b0 : alarm_r);
   assign gate_nxt  = gate_ok ? CMD_I.gate_enable : gate_r;

   // password lock per access system
   always_comb
   begin
      unlock_nxt = unlock_r;
      if (CMD_I.pwd_relock)
      begin
         unlock_nxt[CMD_I.port_sel] = 1'b0;
      end
      else if (CMD_I.pwd_enter)
      begin
         unlock_nxt[CMD_I.port_sel] = pwd_match;
      end
   end

   // event sequencer: one record at boot, one per gate change
   always_comb
   begin
      case (ev_st_r)
         EV_BOOT: ev_st_nxt = EV_IDLE;
         EV_IDLE: ev_st_nxt = gate_changes ? EV_LOG : EV_IDLE;
         EV_LOG:  ev_st_nxt = gate_changes ? EV_LOG : EV_IDLE;
         default: ev_st_nxt = EV_IDLE;
      endcase
   end

   // pin synchronisers
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_N_I)
      begin
         in_s1_r    <= '0;
         in_s2_r    <= '0;
         inop_s1_r  <= 1'b0;
         inop_s2_r  <= 1'b0;
         alarm_s1_r <= 1'b0;
         alarm_s2_r <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         in_s1_r    <= LOGIC_IN_I;
         in_s2_r    <= in_s1_r;
         inop_s1_r  <= INOPERATIVE_I;
         inop_s2_r  <= inop_s1_r;
         alarm_s1_r <= ALARM_ACTIVE_I;
         alarm_s2_r <= alarm_s1_r;
      end
   end

   // flag snapshots, all words on the same edge
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_N_I)
      begin
         in_flag_r   <= '0;
         out_flag_r  <= '0;
         prot_flag_r <= '0;
      end
      else if (CLK_EN_I)
      begin
         in_flag_r   <= in_s2_r;
         out_flag_r  <= out_flag_nxt;
         prot_flag_r <= prot_nxt;
      end
   end

   // contacts, alarm and gate
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_N_I)
      begin
         contact_r <= '0;
         latch_r   <= '0;
         alarm_r   <= 1'b0;
         gate_r    <= 1'b1;
         oos_r     <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         contact_r <= contact_nxt;
         latch_r   <= latch_nxt;
         alarm_r   <= alarm_nxt;
         gate_r    <= gate_nxt;
         oos_r     <= ~gate_nxt;
      end
   end

   // password, clock
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_N_I)
      begin
         unlock_r <= '0;
         pwd_r    <= PWD_DEFAULT;
         rtc_r    <= RTC_RESET;
      end
      else if (CLK_EN_I)
      begin
         unlock_r <= unlock_nxt;
         if (pwd_change_ok)
         begin
            pwd_r <= CMD_I.pwd_data;
         end
         // settable value; advancing the clock is left to the timebase
         if (CMD_I.rtc_write)
         begin
            rtc_r <= CMD_I.rtc_data;
         end
      end
   end

   // event outputs
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_N_I)
      begin
         ev_st_r    <= EV_BOOT;
         ev_valid_r <= 1'b0;
         ev_data_r  <= '0;
         ev_erase_r <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         ev_st_r    <= ev_st_nxt;
         ev_valid_r <= (ev_st_r == EV_BOOT) | gate_changes;
         ev_data_r  <= '{reset_cause: (ev_st_r == EV_BOOT), gate_state: gate_nxt};
         ev_erase_r <= ev_clear_ok;
      end
   end

   // outputs straight from flip-flops
   assign INPUT_FLAG_O     = in_flag_r;
   assign OUTPUT_FLAG_O    = out_flag_r;
   assign PROT_FLAG_O      = prot_flag_r;
   assign SCHEME_IN_O      = in_flag_r;
   assign SCHEME_PROT_O    = prot_flag_r;
   assign CONTACT_O        = contact_r;
   assign OUT_OF_SERVICE_O = oos_r;
   assign ALARM_PRESENT_O  = alarm_r;
   assign GATE_ENABLED_O   = gate_r;
   assign UNLOCKED_O       = unlock_r;
   assign EV_VALID_O       = ev_valid_r;
   assign EV_DATA_O        = ev_data_r;
   assign EV_ERASE_O       = ev_erase_r;
   assign RTC_O            = rtc_r;

endmodule // ascc_top

// >>> verification/ascc_asserts.sv
`timescale 1ns/1ps
module ascc_asserts
   import ascc_pkg::*;
(
   // clock and reset
   input wire logic                        CORE_CLK_I,
   input wire logic                        RST_N_I,
   input wire logic                        CLK_EN_I,
   // stimulus seen by the block
   input wire logic [ascc_pkg::PROT_W-1:0] PROT_FUNC_I,
   input wire logic [ascc_pkg::OUT_W-1:0]  SCHEME_OUT_I,
   input wire logic [ascc_pkg::OUT_W-1:0]  TEST_OUT_I,
   input wire logic [ascc_pkg::OUT_W-1:0]  LATCH_MASK_I,
   input wire ascc_pkg::ascc_cmd_t         CMD_I,
   // block outputs
   input wire logic [ascc_pkg::PROT_W-1:0] PROT_FLAG_O,
   input wire logic [ascc_pkg::OUT_W-1:0]  OUTPUT_FLAG_O,
   input wire logic [ascc_pkg::OUT_W-1:0]  CONTACT_O,
   input wire logic                        OUT_OF_SERVICE_O,
   input wire logic                        GATE_ENABLED_O,
   input wire logic [1:0]                  UNLOCKED_O,
   input wire logic                        EV_VALID_O,
   input wire ascc_pkg::ascc_evt_t         EV_DATA_O,
   input wire logic                        EV_ERASE_O,
   input wire logic [ascc_pkg::RTC_W-1:0]  RTC_O
);
   // erase request that the open lock of its port lets through
   wire ev_ok = CMD_I.ev_clear & UNLOCKED_O[CMD_I.port_sel];
   // frozen cycles are not judged
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I || !CLK_EN_I);
   // bit 0 is a contact bit, so masks keep it out of the scheme compares
   property p_compl; $past(RST_N_I) |-> PROT_FLAG_O[2] == !PROT_FLAG_O[1]; endproperty
   property p_prot; $past(RST_N_I) |-> (PROT_FLAG_O & 20'hffffd) ==
      ($past(PROT_FUNC_I) & 20'hffffd); endproperty
   property p_on; GATE_ENABLED_O && $past(GATE_ENABLED_O) && $past(RST_N_I) &&
      $past(LATCH_MASK_I) == 16'h0 |->
      (CONTACT_O & 16'hfffe) == ($past(SCHEME_OUT_I) & 16'hfffe); endproperty
   property p_off; !GATE_ENABLED_O && !$past(GATE_ENABLED_O) |-> OUT_OF_SERVICE_O &&
      (CONTACT_O & 16'hfffe) == ($past(TEST_OUT_I) & 16'hfffe); endproperty
   property p_flag; $past(RST_N_I) && $past(LATCH_MASK_I) == 16'h0 |->
      (OUTPUT_FLAG_O & 16'hfffe) == ($past(SCHEME_OUT_I) & 16'hfffe); endproperty
   property p_lock; CMD_I.gate_write && !UNLOCKED_O[CMD_I.port_sel] |=>
      $stable(GATE_ENABLED_O); endproperty
   property p_gevt; $changed(GATE_ENABLED_O) |-> EV_VALID_O && !EV_DATA_O.reset_cause &&
      EV_DATA_O.gate_state == GATE_ENABLED_O; endproperty
   property p_boot; $rose(RST_N_I) |=> EV_VALID_O && EV_DATA_O == 2'b11; endproperty
   property p_erase; $past(RST_N_I) |-> EV_ERASE_O == $past(ev_ok); endproperty
   property p_rtc; CMD_I.rtc_write |=> RTC_O == $past(CMD_I.rtc_data); endproperty
   a_compl: assert property (p_compl) else $error("vb bits not complementary");
   a_prot: assert property (p_prot) else $error("protection word wrong");
   a_on: assert property (p_on) else $error("scheme not on contacts");
   a_off: assert property (p_off) else $error("inhibited contacts wrong");
   a_flag: assert property (p_flag) else $error("output word wrong");
   a_lock: assert property (p_lock) else $error("locked gate write taken");
   a_gevt: assert property (p_gevt) else $error("gate change not logged");
   a_boot: assert property (p_boot) else $error("reset not logged");
   a_erase: assert property (p_erase) else $error("erase pulse wrong");
   a_rtc: assert property (p_rtc) else $error("clock value not set");
   // main scenarios reached
   c_gate: cover property ($fell(GATE_ENABLED_O));
   c_erase: cover property (EV_ERASE_O);
   c_unlock: cover property ($rose(UNLOCKED_O[0]));
endmodule // ascc_asserts

bind ascc_top ascc_asserts u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
   .CLK_EN_I(CLK_EN_I), .PROT_FUNC_I(PROT_FUNC_I), .SCHEME_OUT_I(SCHEME_OUT_I),
   .TEST_OUT_I(TEST_OUT_I), .LATCH_MASK_I(LATCH_MASK_I), .CMD_I(CMD_I),
   .PROT_FLAG_O(PROT_FLAG_O), .OUTPUT_FLAG_O(OUTPUT_FLAG_O), .CONTACT_O(CONTACT_O),
   .OUT_OF_SERVICE_O(OUT_OF_SERVICE_O), .GATE_ENABLED_O(GATE_ENABLED_O),
   .UNLOCKED_O(UNLOCKED_O), .EV_VALID_O(EV_VALID_O), .EV_DATA_O(EV_DATA_O),
   .EV_ERASE_O(EV_ERASE_O), .RTC_O(RTC_O));

// >>> verification/ascc_host_mdl.sv
`timescale 1ns/1ps
module ascc_host_mdl
   import ascc_pkg::*;
(
   // clock
   input  wire logic          clk_i,
   // command towards the block
   output ascc_pkg::ascc_cmd_t cmd_o
);
   // idle until the first request
   initial cmd_o = '0;
   // op: 0 password, 1 relock, 2 alarm clear, 3 gate, 4 event clear, else clock set
   task automatic issue(input int op, input logic port, input logic [47:0] d);
      ascc_cmd_t c;
      c = '0;
      c.port_sel = port;
      c.pwd_data = d[31:0];
      c.rtc_data = d;
      c.gate_enable = d[0];
      case (op)
         0: c.pwd_enter = 1'b1;
         1: c.pwd_relock = 1'b1;
         2: c.alarm_clear = 1'b1;
         3: c.gate_write = 1'b1;
         4: c.ev_clear = 1'b1;
         default: c.rtc_write = 1'b1;
      endcase
      // one-cycle pulse, so a request is never taken twice
      @(posedge clk_i);
      cmd_o <= c;
      @(posedge clk_i);
      cmd_o <= '0;
   endtask
endmodule // ascc_host_mdl

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import ascc_pkg::*;
   // stimulus
   logic clk, rst_n, inop, alarm;
   logic [IN_W-1:0] li, in_f, sch_in;
   logic [PROT_W-1:0] pf, prot_f, sch_prot;
   logic [OUT_W-1:0] so, to, out_f, con;
   ascc_cmd_t cmd;
   // observed
   logic oos, alm, gate, ev_v, ev_e;
   logic [1:0] unl;
   ascc_evt_t ev_d;
   logic [RTC_W-1:0] rtc, rv;
   int bad_count, samples_checked, erase_seen;

   ascc_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1), .LOGIC_IN_I(li),
      .PROT_FUNC_I(pf), .SCHEME_OUT_I(so), .TEST_OUT_I(to), .LATCH_MASK_I(16'h0),
      .INOPERATIVE_I(inop), .ALARM_ACTIVE_I(alarm), .CMD_I(cmd), .INPUT_FLAG_O(in_f),
      .OUTPUT_FLAG_O(out_f), .PROT_FLAG_O(prot_f), .SCHEME_IN_O(sch_in),
      .SCHEME_PROT_O(sch_prot), .CONTACT_O(con), .OUT_OF_SERVICE_O(oos),
      .ALARM_PRESENT_O(alm), .GATE_ENABLED_O(gate), .UNLOCKED_O(unl), .EV_VALID_O(ev_v),
      .EV_DATA_O(ev_d), .EV_ERASE_O(ev_e), .RTC_O(rtc));
   ascc_host_mdl u_host (.clk_i(clk), .cmd_o(cmd));

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // erase pulses tallied as they pass
   always @(posedge clk) if (ev_e === 1'b1) erase_seen++;

   // bit 1 is always rebuilt from the fault bit
   function automatic logic [PROT_W-1:0] exp_prot(input logic [PROT_W-1:0] p);
      return {p[19:3], p[2], ~p[2], p[0]};
   endfunction
   // alarm contact is energised while healthy
   function automatic logic [OUT_W-1:0] exp_con(input logic g, input logic [OUT_W-1:0] s,
      input logic [OUT_W-1:0] t, input logic i);
      return {(g ? s[15:1] : t[15:1]), ~i};
   endfunction

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // random flag traffic, first pass forces a voltage balance fault
   task automatic flags(input logic g);
      for (int k = 0; k < 12; k++)
      begin
         @(posedge clk);
         li <= 14'($urandom);
         pf <= (k == 0) ? 20'h00004 : 20'($urandom);
         so <= 16'($urandom);
         to <= 16'($urandom);
         inop <= 1'($urandom);
         wt(4);
         chk("input_flag", in_f, li);
         chk("scheme_in", sch_in, li);
         chk("prot_flag", prot_f, exp_prot(pf));
         chk("scheme_prot", sch_prot, exp_prot(pf));
         chk("output_flag", out_f, {so[15:1], inop});
         chk("contact", con, exp_con(g, so, to, inop));
      end
      $display("test flags gate=%0d done", g);
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      {li, pf, so, to, inop, alarm, rst_n} = '0;
      {bad_count, samples_checked, erase_seen} = '0;
      void'($urandom(32'he969));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      wt(1);
      chk("boot_event", {ev_v, ev_d, gate, unl}, 6'h3c);
      flags(1'b1);
      u_host.issue(3, 1'b0, 48'h0);
      wt(2);
      chk("gate_locked", gate, 1'b1);
      u_host.issue(0, 1'b0, 48'h42414141);
      wt(2);
      chk("unlock_bad", unl, 2'b00);
      u_host.issue(0, 1'b0, 48'(PWD_DEFAULT));
      wt(2);
      chk("unlock_front", unl, 2'b01);
      u_host.issue(4, 1'b1, 48'h0);
      wt(1);
      chk("erase_locked", erase_seen, 0);
      $display("test lock done");
      @(posedge clk);
      alarm <= 1'b1;
      wt(4);
      chk("alarm_on", alm, 1'b1);
      u_host.issue(4, 1'b0, 48'h0);
      wt(1);
      chk("erase", erase_seen, 1);
      chk("alarm_kept", alm, 1'b1);
      @(posedge clk);
      alarm <= 1'b0;
      wt(4);
      chk("alarm_held", alm, 1'b1);
      u_host.issue(2, 1'b0, 48'h0);
      wt(2);
      chk("alarm_clear", alm, 1'b0);
      $display("test alarm done");
      u_host.issue(3, 1'b0, 48'h0);
      wt(0);
      chk("gate_off", {gate, oos, ev_v, ev_d}, 5'h0c);
      flags(1'b0);
      u_host.issue(3, 1'b0, 48'h1);
      wt(0);
      chk("gate_on", {gate, oos, ev_v, ev_d}, 5'h15);
      rv = {16'($urandom), $urandom};
      u_host.issue(5, 1'b1, rv);
      wt(0);
      chk("rtc", rtc, rv);
      u_host.issue(1, 1'b0, 48'h0);
      wt(2);
      chk("relock", unl, 2'b00);
      $display("test gate and clock done");
      close_out;
   end
   // hang guard, well beyond the 167 cycles needed
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      close_out;
   end
endmodule // tb_top
